// ### rtl/phy_page_pkg.sv
// Constants for the paged management register bank of a dual-port transceiver.
// Assumes an APB master in the pclk domain and per-port event pulses synchronous to pclk.
// Contract
// - Page select is 16 bits, read/write, resets zero; zero selects main space.
// - Page values one to four steer registers 16-30 to that extended space.
// - Page value sixteen steers registers 0-30 to the general I/O space.
// - Registers 0-15 ignore extended pages and stay in the standard space.
// - Extended page 1 map: 16, 18, 19 here; 17, 21-22, 24-28 reserved.
// - Transmit remote fault field, read/write, resets 00, drives the sent code.
// - Read-only field shows remote fault bits received from the link partner.
// - Permission bit, default one, allows 1000BASE-X link-up; zero suppresses it.
// - Permission bit, default one, allows 100BASE-FX link-up; zero suppresses it.
// - Far-end fault flag sets on detection and clears itself when read.
// - Counter top bit shows a packet arrived since last read; read clears it.
// - Good-CRC count modulo ten thousand, wraps after 9999, clears on read.
// - Four per-LED bits, reset zero, switch each LED to the extended mode set.
// - After low-power hold release LEDs blink unless blink-suppress is one.
// - Fast link failure bit from port 0 only drives the pin; else general I/O.
// - Crossover field: 00 automatic, 01 reserved, 10 forced MDI, 11 forced MDI-X.
// - Polarity bit one makes signal detect active-low; zero active-high.

package phy_page_pkg;

	// ==========================================================
	// Ports and address layout
	localparam int          NUM_PORTS      = 2;
	localparam int          REG_NUM_LSB    = 2;
	localparam int          PORT_BIT       = 7;
	localparam int          IRQ_BIT        = 8;
	localparam logic [11:0] IRQ_STATUS_ADDR = 12'h100;
	localparam logic [11:0] IRQ_MASK_ADDR   = 12'h104;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [4:0] FIBER_MEDIA_CONTROL_IDX     = 5'h10;
	localparam logic [4:0] GOOD_CRC_PACKET_COUNTER_IDX = 5'h12;
	localparam logic [4:0] EXTENDED_MODE_CONTROL_IDX   = 5'h13;
	localparam logic [4:0] REGISTER_PAGE_SELECT_IDX    = 5'h1F;
	localparam logic [4:0] PAGED_FIRST_IDX             = 5'h10;

	// ==========================================================
	// Page values and resolved spaces
	localparam logic [15:0] PAGE_MAIN  = 16'h0000;
	localparam logic [15:0] PAGE_EXT1  = 16'h0001;
	localparam logic [15:0] PAGE_EXT4  = 16'h0004;
	localparam logic [15:0] PAGE_GPIO  = 16'h0010;
	localparam logic [2:0]  SPACE_STD  = 3'h0;
	localparam logic [2:0]  SPACE_MAIN = 3'h5;
	localparam logic [2:0]  SPACE_GPIO = 3'h6;
	localparam logic [2:0]  SPACE_NONE = 3'h7;

	// ==========================================================
	// Field positions
	localparam int TX_RF_LSB      = 14;
	localparam int PARTNER_RF_LSB = 12;
	localparam int ALLOW_1000X    = 9;
	localparam int ALLOW_100FX    = 8;
	localparam int FAR_END_FAULT  = 6;
	localparam int PKT_SINCE_READ = 15;
	localparam int LED_EXT_LSB    = 12;
	localparam int BLINK_SUPPRESS = 11;
	localparam int FAST_LINK_FAIL = 4;
	localparam int XOVER_LSB      = 2;
	localparam int DETECT_POL     = 0;

	// ==========================================================
	// Reset values and counts
	localparam logic [15:0] PAGE_RESET    = 16'h0000;
	localparam logic [1:0]  TX_RF_RESET   = 2'h0;
	localparam logic        ALLOW_RESET   = 1'b1;
	localparam logic [3:0]  LED_EXT_RESET = 4'h0;
	localparam logic [1:0]  XOVER_RESET   = 2'h0;
	localparam logic [13:0] CRC_COUNT_MAX = 14'h270F;
	localparam logic [13:0] CRC_COUNT_ONE = 14'h0001;

endpackage

// ### rtl/phy_page_select_regs.sv
// Paged management register bank for two transceiver ports behind an APB slave.
// Assumes event and pin inputs are synchronous to pclk; one wait state per transfer.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module phy_page_select_regs (
	input  wire logic                                          pclk,
	input  wire logic                                          presetn,
	input  wire logic                                          psel,
	input  wire logic                                          penable,
	input  wire logic                                          pwrite,
	input  wire logic [11:0]                                   paddr,
	input  wire logic [31:0]                                   pwdata,
	output logic      [31:0]                                   prdata,
	output logic                                               pready,
	output logic                                               pslverr,
	input  wire logic [phy_page_pkg::NUM_PORTS-1:0][1:0]       link_partner_remote_fault,
	input  wire logic [phy_page_pkg::NUM_PORTS-1:0]            far_end_fault_detect,
	input  wire logic [phy_page_pkg::NUM_PORTS-1:0]            good_crc_packet,
	input  wire logic [phy_page_pkg::NUM_PORTS-1:0][1:0]       signal_detect_input,
	input  wire logic                                          low_power_hold_pin,
	output logic      [phy_page_pkg::NUM_PORTS-1:0][1:0]       tx_remote_fault,
	output logic      [phy_page_pkg::NUM_PORTS-1:0]            allow_1000x_linkup,
	output logic      [phy_page_pkg::NUM_PORTS-1:0]            allow_100fx_linkup,
	output logic      [phy_page_pkg::NUM_PORTS-1:0][3:0]       led_extended_mode,
	output logic      [phy_page_pkg::NUM_PORTS-1:0]            led_reset_blink,
	output logic      [phy_page_pkg::NUM_PORTS-1:0][1:0]       crossover_mode,
	output logic      [phy_page_pkg::NUM_PORTS-1:0][1:0]       signal_detect,
	output logic                                               fast_link_fail_pin_en,
	output logic      [2:0]                                    last_access_space,
	output logic      [4:0]                                    last_access_reg,
	output logic                                               irq
);
	import phy_page_pkg::*;

	localparam int NP = NUM_PORTS;

	// ==========================================================
	// Space decode
	function automatic logic [2:0] resolve_space(input logic [15:0] page, input logic [4:0] rnum);
		logic [2:0] sp;
		// Pages 5-15 and 17 up reach nothing in registers 16-30
		sp = SPACE_NONE;
		if (page == PAGE_GPIO) begin
			sp = SPACE_GPIO;
		end else if (rnum < PAGED_FIRST_IDX) begin
			sp = SPACE_STD;
		end else if (page == PAGE_MAIN) begin
			sp = SPACE_MAIN;
		end else if (page >= PAGE_EXT1 && page <= PAGE_EXT4) begin
			sp = page[2:0];
		end
		return sp;
	endfunction

	// ==========================================================
	// State
	logic [NP-1:0][15:0] page_reg,       page_next;
	logic [NP-1:0][1:0]  tx_rf_reg,      tx_rf_next;
	logic [NP-1:0]       allow_x_reg,    allow_x_next;
	logic [NP-1:0]       allow_fx_reg,   allow_fx_next;
	logic [NP-1:0]       fef_reg,        fef_next;
	logic [NP-1:0]       pkt_reg,        pkt_next;
	logic [NP-1:0][13:0] cnt_reg,        cnt_next;
	logic [NP-1:0][3:0]  led_ext_reg,    led_ext_next;
	logic [NP-1:0]       blink_sup_reg,  blink_sup_next;
	logic                flf_reg,        flf_next;
	logic [NP-1:0][1:0]  xover_reg,      xover_next;
	logic [NP-1:0]       pol_reg,        pol_next;
	logic [NP-1:0][1:0]  det_reg,        det_next;
	logic [NP-1:0]       blink_reg,      blink_next;
	logic                hold_reg,       hold_next;

	// Interrupt and bus state
	logic [2*NP-1:0]     status_reg,     status_next;
	logic [2*NP-1:0]     mask_reg,       mask_next;
	logic                irq_reg,        irq_next;
	logic [31:0]         rdata_reg,      rdata_next;
	logic                ready_reg,      ready_next;
	logic                err_reg,        err_next;
	logic [2:0]          space_reg,      space_next;
	logic [4:0]          rnum_reg,       rnum_next;

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic        access;
		logic        port;
		logic [4:0]  rnum;
		logic [2:0]  space;
		logic [15:0] rd;
		logic [15:0] wd;
		logic        wr;
		logic        rd_clr;

		page_next      = page_reg;
		tx_rf_next     = tx_rf_reg;
		allow_x_next   = allow_x_reg;
		allow_fx_next  = allow_fx_reg;
		fef_next       = fef_reg;
		pkt_next       = pkt_reg;
		cnt_next       = cnt_reg;
		led_ext_next   = led_ext_reg;
		blink_sup_next = blink_sup_reg;
		flf_next       = flf_reg;
		xover_next     = xover_reg;
		pol_next       = pol_reg;
		status_next    = status_reg;
		mask_next      = mask_reg;
		rdata_next     = rdata_reg;
		// Error lives only in the pready cycle, so pslverr needs no gate
		err_next       = 1'b0;
		space_next     = space_reg;
		rnum_next      = rnum_reg;
		// Pin level of the last cycle, for the release edge
		hold_next      = low_power_hold_pin;
		rd             = 16'h0000;
		wd             = pwdata[15:0];
		rd_clr         = 1'b0;

		// Work is done in the first access cycle; pready follows one cycle later
		access     = psel && penable && !ready_reg;
		ready_next = access;
		// Bit 7 picks the port, bits 6:2 the register
		port       = paddr[PORT_BIT];
		rnum       = paddr[REG_NUM_LSB +: 5];
		wr         = access && pwrite && !paddr[IRQ_BIT];
		space      = resolve_space(page_reg[port], rnum);

		if (rnum == REGISTER_PAGE_SELECT_IDX) begin
			rd = page_reg[port];
		end else if (space == PAGE_EXT1[2:0]) begin
			case (rnum)
				FIBER_MEDIA_CONTROL_IDX: begin
					rd[TX_RF_LSB +: 2]  = tx_rf_reg[port];
					rd[PARTNER_RF_LSB +: 2] = link_partner_remote_fault[port];
					rd[ALLOW_1000X]     = allow_x_reg[port];
					rd[ALLOW_100FX]     = allow_fx_reg[port];
					rd[FAR_END_FAULT]   = fef_reg[port];
				end
				GOOD_CRC_PACKET_COUNTER_IDX: begin
					rd[PKT_SINCE_READ]  = pkt_reg[port];
					rd[13:0]            = cnt_reg[port];
				end
				EXTENDED_MODE_CONTROL_IDX: begin
					rd[LED_EXT_LSB +: 4] = led_ext_reg[port];
					rd[BLINK_SUPPRESS]   = blink_sup_reg[port];
					// One fast link pin serves both ports; port 1 reads zero
					rd[FAST_LINK_FAIL]   = port ? 1'b0 : flf_reg;
					rd[XOVER_LSB +: 2]   = xover_reg[port];
					rd[DETECT_POL]       = pol_reg[port];
				end
				default: begin
					rd = 16'h0000;
				end
			endcase
		end

		if (access) begin
			rnum_next = rnum;
			if (paddr[IRQ_BIT]) begin
				space_next = SPACE_NONE;
				err_next   = (paddr != IRQ_STATUS_ADDR) && (paddr != IRQ_MASK_ADDR);
				rdata_next = 32'h0000_0000;
				if (paddr == IRQ_STATUS_ADDR) begin
					rdata_next[2*NP-1:0] = status_reg;
				end else if (paddr == IRQ_MASK_ADDR) begin
					rdata_next[2*NP-1:0] = mask_reg;
				end
				// Write one to clear; events of this cycle still set below
				if (pwrite && paddr == IRQ_STATUS_ADDR) begin
					status_next = status_reg & ~pwdata[2*NP-1:0];
				end
				if (pwrite && paddr == IRQ_MASK_ADDR) begin
					mask_next = pwdata[2*NP-1:0];
				end
			end else begin
				err_next   = 1'b0;
				// Page select register always sits in the main space
				space_next = (rnum == REGISTER_PAGE_SELECT_IDX) ? SPACE_MAIN : space;
				rdata_next = {16'h0000, rd};
				// Only reads clear the self-clearing bits
				rd_clr     = !pwrite;
			end
		end

		if (wr && rnum == REGISTER_PAGE_SELECT_IDX) begin
			page_next[port] = wd;
		end
		if (wr && space == PAGE_EXT1[2:0]) begin
			case (rnum)
				FIBER_MEDIA_CONTROL_IDX: begin
					tx_rf_next[port]    = wd[TX_RF_LSB +: 2];
					allow_x_next[port]  = wd[ALLOW_1000X];
					allow_fx_next[port] = wd[ALLOW_100FX];
				end
				EXTENDED_MODE_CONTROL_IDX: begin
					led_ext_next[port]   = wd[LED_EXT_LSB +: 4];
					blink_sup_next[port] = wd[BLINK_SUPPRESS];
					if (!port) begin
						flf_next = wd[FAST_LINK_FAIL];
					end
					xover_next[port]     = wd[XOVER_LSB +: 2];
					pol_next[port]       = wd[DETECT_POL];
				end
				default: begin
					wr = 1'b0;
				end
			endcase
		end

		for (int p = 0; p < NP; p++) begin
			if (rd_clr && port == p[0] && space == PAGE_EXT1[2:0]
				&& rnum == FIBER_MEDIA_CONTROL_IDX) begin
				fef_next[p] = 1'b0;
			end
			if (rd_clr && port == p[0] && space == PAGE_EXT1[2:0]
				&& rnum == GOOD_CRC_PACKET_COUNTER_IDX) begin
				pkt_next[p] = 1'b0;
				cnt_next[p] = 14'h0000;
			end
			// Event in the clearing cycle wins over the clear
			// fault sets flag
			if (far_end_fault_detect[p]) begin
				fef_next[p]      = 1'b1;
				status_next[2*p] = 1'b1;
			end
			if (good_crc_packet[p]) begin
				pkt_next[p]        = 1'b1;
				status_next[2*p+1] = 1'b1;
				// modulo wrap
				// Counts from the cleared value, so read and packet together leave one
				if (cnt_next[p] == CRC_COUNT_MAX) begin
					cnt_next[p] = 14'h0000;
				end else begin
					cnt_next[p] = cnt_next[p] + CRC_COUNT_ONE;
				end
			end
			det_next[p]    = pol_reg[p] ? ~signal_detect_input[p] : signal_detect_input[p];
			// Hold resets low, so a pin held low through reset gives no pulse
			// blink on release
			blink_next[p]  = hold_reg && !low_power_hold_pin && !blink_sup_reg[p];
		end

		// Status bits set in this cycle already count toward the interrupt
		irq_next = |(status_next & mask_next);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_reg      <= {NP{PAGE_RESET}};
			tx_rf_reg     <= {NP{TX_RF_RESET}};
			allow_x_reg   <= {NP{ALLOW_RESET}};
			allow_fx_reg  <= {NP{ALLOW_RESET}};
			fef_reg       <= '0;
			pkt_reg       <= '0;
			cnt_reg       <= '0;
			led_ext_reg   <= {NP{LED_EXT_RESET}};
			blink_sup_reg <= '0;
			flf_reg       <= 1'b0;
			xover_reg     <= {NP{XOVER_RESET}};
			pol_reg       <= '0;
			det_reg       <= '0;
			blink_reg     <= '0;
			hold_reg      <= 1'b0;
			status_reg    <= '0;
			mask_reg      <= '0;
			irq_reg       <= 1'b0;
			rdata_reg     <= 32'h0000_0000;
			ready_reg     <= 1'b0;
			err_reg       <= 1'b0;
			space_reg     <= SPACE_MAIN;
			rnum_reg      <= 5'h00;
		end else begin
			page_reg      <= page_next;
			tx_rf_reg     <= tx_rf_next;
			allow_x_reg   <= allow_x_next;
			allow_fx_reg  <= allow_fx_next;
			fef_reg       <= fef_next;
			pkt_reg       <= pkt_next;
			cnt_reg       <= cnt_next;
			led_ext_reg   <= led_ext_next;
			blink_sup_reg <= blink_sup_next;
			flf_reg       <= flf_next;
			xover_reg     <= xover_next;
			pol_reg       <= pol_next;
			det_reg       <= det_next;
			blink_reg     <= blink_next;
			hold_reg      <= hold_next;
			status_reg    <= status_next;
			mask_reg      <= mask_next;
			irq_reg       <= irq_next;
			rdata_reg     <= rdata_next;
			ready_reg     <= ready_next;
			err_reg       <= err_next;
			space_reg     <= space_next;
			rnum_reg      <= rnum_next;
		end
	end

	// ==========================================================
	// Outputs, all straight from flip-flops
	assign prdata                = rdata_reg;
	assign pready                = ready_reg;
	assign pslverr               = err_reg;
	assign tx_remote_fault       = tx_rf_reg;
	assign allow_1000x_linkup    = allow_x_reg;
	assign allow_100fx_linkup    = allow_fx_reg;
	assign led_extended_mode     = led_ext_reg;
	assign led_reset_blink       = blink_reg;
	assign crossover_mode        = xover_reg;
	assign signal_detect         = det_reg;
	assign fast_link_fail_pin_en = flf_reg;
	assign last_access_space     = space_reg;
	assign last_access_reg       = rnum_reg;
	assign irq                   = irq_reg;

endmodule

`default_nettype wire

// ### bench/phy_page_select_regs_sva.sv
// Assertion checker for the paged register bank: bus timing and page routing.
// Sees only top ports; attached by the bind at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module phy_page_select_regs_sva (
	input wire logic                                    pclk,
	input wire logic                                    presetn,
	input wire logic                                    psel,
	input wire logic                                    penable,
	input wire logic                                    pwrite,
	input wire logic [11:0]                             paddr,
	input wire logic [31:0]                             pwdata,
	input wire logic                                    pready,
	input wire logic                                    pslverr,
	input wire logic [phy_page_pkg::NUM_PORTS-1:0][1:0] signal_detect_input,
	input wire logic [phy_page_pkg::NUM_PORTS-1:0][1:0] tx_remote_fault,
	input wire logic [phy_page_pkg::NUM_PORTS-1:0][1:0] signal_detect,
	input wire logic                                    fast_link_fail_pin_en,
	input wire logic [2:0]                              last_access_space
);
	import phy_page_pkg::*;
	// ==========================================================
	// Shadow of each port's page, updated at the taking edge
	logic                  take;
	logic [1:0][15:0]      pg_reg;
	logic [15:0]           pg;
	logic [2:0]            pg3;
	logic [4:0]            rn;
	logic [1:0]            txw;
	logic [1:0][1:0]       sdi_reg;
	logic [1:0]            pol_sh;
	logic [1:0]            pol_d;
	assign take = psel && penable && !pready && paddr[11:8] == 4'h0;
	assign rn = paddr[6:2];
	assign pg = pg_reg[paddr[PORT_BIT]];
	assign pg3 = pg[2:0];
	assign txw = pwdata[15:14];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pg_reg <= '0;
		end else if (take && pwrite && rn == REGISTER_PAGE_SELECT_IDX) begin
			pg_reg[paddr[PORT_BIT]] <= pwdata[15:0];
		end
	end
	always_ff @(posedge pclk) begin
		sdi_reg <= signal_detect_input;
	end
	// Shadow of each port's polarity bit, and its value one cycle late
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pol_sh <= '0;
			pol_d  <= '0;
		end else begin
			pol_d <= pol_sh;
			if (take && pwrite && rn == EXTENDED_MODE_CONTROL_IDX && pg == PAGE_EXT1) begin
				pol_sh[paddr[PORT_BIT]] <= pwdata[DETECT_POL];
			end
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Assertions
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	a_pready_one_wait: assert property (s_wait |=> pready ##1 !pready)
		else $error("pready not one pulse after the access edge");
	a_std_space: assert property (take && rn < 5'h10 && pg != PAGE_GPIO
		|=> last_access_space == SPACE_STD) else $error("low register left std space");
	a_ext_space: assert property (take && rn >= 5'h10 && rn < 5'h1F && pg >= PAGE_EXT1
		&& pg <= PAGE_EXT4 |=> last_access_space == $past(pg3))
		else $error("extended page not routed");
	a_gpio_space: assert property (take && rn < 5'h1F && pg == PAGE_GPIO
		|=> last_access_space == SPACE_GPIO) else $error("general io page not routed");
	a_main_space: assert property (take && rn >= 5'h10 && pg == PAGE_MAIN
		|=> last_access_space == SPACE_MAIN) else $error("main page not routed");
	a_tx_fault_write: assert property (take && pwrite && !paddr[PORT_BIT]
		&& rn == FIBER_MEDIA_CONTROL_IDX && pg == PAGE_EXT1
		|=> tx_remote_fault[0] == $past(txw)) else $error("transmit fault not written");
	a_fast_pin_port1: assert property (take && pwrite && paddr[PORT_BIT]
		|=> $stable(fast_link_fail_pin_en)) else $error("port 1 moved fast link pin");
	a_detect_polarity: assert property ($past(presetn)
		|-> signal_detect[0] == (pol_d[0] ? ~sdi_reg[0] : sdi_reg[0])
		&& signal_detect[1] == (pol_d[1] ? ~sdi_reg[1] : sdi_reg[1]))
		else $error("signal detect polarity wrong");
	a_slverr_area: assert property (pready |-> pslverr == (paddr[11:8] != 4'h0
		&& paddr != IRQ_STATUS_ADDR && paddr != IRQ_MASK_ADDR)) else $error("pslverr wrong");
endmodule
bind phy_page_select_regs phy_page_select_regs_sva u_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .signal_detect_input(signal_detect_input),
	.tx_remote_fault(tx_remote_fault), .signal_detect(signal_detect),
	.fast_link_fail_pin_en(fast_link_fail_pin_en), .last_access_space(last_access_space));
`default_nettype wire

// ### bench/mgmt_host_model.sv
// Management host model: APB master issuing one transfer per task call.
// Assumes pclk and a slave that raises pready in the access phase.
`timescale 1ns/1ns
`default_nettype none
module mgmt_host_model (
	input wire logic        pclk,
	output logic            psel,
	output logic            penable,
	output logic            pwrite,
	output logic [11:0]     paddr,
	output logic [31:0]     pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// Released address and data lines show the inverse so a stale value never passes as live
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ### bench/phy_page_select_regs_tb.sv
// Self-checking bench for the paged register bank.
// Assumes the host model drives APB; events and pins driven here.
`timescale 1ns/1ns
`default_nettype none
module phy_page_select_regs_tb;
	import phy_page_pkg::*;
	logic            pclk = 1'b0;
	logic            presetn = 1'b0;
	logic            psel, penable, pwrite, pready, pslverr, irq, fast_link_fail_pin_en;
	logic [11:0]     paddr;
	logic [31:0]     pwdata, prdata, rdata;
	logic            rerr;
	logic [1:0][1:0] link_partner_remote_fault = 4'h6;
	logic [1:0][1:0] signal_detect_input = 4'h9;
	logic [1:0]      far_end_fault_detect = 2'h0;
	logic [1:0]      good_crc_packet = 2'h0;
	logic            low_power_hold_pin = 1'b1;
	logic [1:0][1:0] tx_remote_fault, crossover_mode, signal_detect;
	logic [1:0]      allow_1000x_linkup, allow_100fx_linkup, led_reset_blink, seen;
	logic [1:0][3:0] led_extended_mode;
	logic [2:0]      last_access_space;
	logic [4:0]      last_access_reg;
	int              n_mismatch = 0;
	int              total_checks = 0;
	always #5 pclk = ~pclk;
	phy_page_select_regs u_phy_page_select_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link_partner_remote_fault(link_partner_remote_fault),
		.far_end_fault_detect(far_end_fault_detect), .good_crc_packet(good_crc_packet),
		.signal_detect_input(signal_detect_input), .low_power_hold_pin(low_power_hold_pin),
		.tx_remote_fault(tx_remote_fault), .allow_1000x_linkup(allow_1000x_linkup),
		.allow_100fx_linkup(allow_100fx_linkup), .led_extended_mode(led_extended_mode),
		.led_reset_blink(led_reset_blink), .crossover_mode(crossover_mode),
		.signal_detect(signal_detect), .fast_link_fail_pin_en(fast_link_fail_pin_en),
		.last_access_space(last_access_space), .last_access_reg(last_access_reg), .irq(irq));
	mgmt_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	// ==========================================================
	// Shared tasks
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask
	function automatic logic [11:0] ad(input logic p, input logic [4:0] i);
		return {4'h0, p, i, 2'b00};
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		u_host.xfer(a, 1'b1, d, rdata, rerr);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
		u_host.xfer(a, 1'b0, 32'h0, rdata, rerr);
		chk(nm, exp, rdata);
	endtask
	task automatic wait_edges(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk("allow_1000x", 2'b11, allow_1000x_linkup);
		chk("allow_100fx", 2'b11, allow_100fx_linkup);
		chk("tx_fault", 4'h0, tx_remote_fault);
		chk("led_ext", 8'h00, led_extended_mode);
		rd(ad(0, 5'h1F), 32'h0, "page_reset");
		$display("test reset done");
	endtask
	task automatic t_pages();
		logic [15:0] pv [7] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h10, 16'h7};
		logic [2:0]  sp [7] = '{3'h5, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
		wr(ad(0, 5'h1F), 32'h1);
		for (int i = 0; i < 7; i++) begin
			wr(ad(1, 5'h1F), {16'h0, pv[i]});
			rd(ad(1, 5'h14), 32'h0, "paged_reg");
			chk("space_high", sp[i], last_access_space);
			rd(ad(1, 5'h03), 32'h0, "std_reg");
			chk("space_low", (pv[i] == 16'h10) ? 3'h6 : 3'h0, last_access_space);
		end
		rd(ad(0, 5'h1F), 32'h1, "page_port0");
		rd(ad(1, 5'h1F), 32'h7, "page_port1");
		chk("reg_num", 5'h1F, last_access_reg);
		$display("test pages done");
	endtask
	task automatic t_fiber();
		rd(ad(0, 5'h10), 32'h2300, "fiber_reset");
		wr(ad(0, 5'h10), 32'hFFFFFCFF);
		chk("tx_fault0", 2'b11, tx_remote_fault[0]);
		chk("allow_1000x", 2'b10, allow_1000x_linkup);
		chk("allow_100fx", 2'b10, allow_100fx_linkup);
		rd(ad(0, 5'h10), 32'hE000, "fiber_rw");
		@(posedge pclk);
		far_end_fault_detect <= 2'b01;
		@(posedge pclk);
		far_end_fault_detect <= 2'b00;
		rd(ad(0, 5'h10), 32'hE040, "far_fault_set");
		rd(ad(0, 5'h10), 32'hE000, "far_fault_clr");
		rd(IRQ_STATUS_ADDR, 32'h1, "irq_status");
		chk("irq_masked", 1'b0, irq);
		wr(IRQ_MASK_ADDR, 32'h1);
		wait_edges(2);
		chk("irq_on", 1'b1, irq);
		wr(IRQ_STATUS_ADDR, 32'h1);
		wait_edges(2);
		chk("irq_off", 1'b0, irq);
		rd(12'h108, 32'h0, "unmapped");
		chk("slverr", 1'b1, rerr);
		$display("test fiber done");
	endtask
	task automatic pulse_crc(input int n);
		@(posedge pclk);
		good_crc_packet <= 2'b11;
		repeat (n) @(posedge pclk);
		good_crc_packet <= 2'b00;
	endtask
	task automatic t_counter();
		pulse_crc(3);
		rd(ad(0, 5'h12), 32'h8003, "crc_count");
		rd(ad(0, 5'h12), 32'h0, "crc_cleared");
		pulse_crc(10001);
		rd(ad(0, 5'h12), 32'h8001, "crc_wrap");
		rd(ad(0, 5'h11), 32'h0, "reserved17");
		rd(IRQ_STATUS_ADDR, 32'hA, "irq_packets");
		wr(IRQ_STATUS_ADDR, 32'hA);
		rd(IRQ_STATUS_ADDR, 32'h0, "irq_w1c");
		$display("test counter done");
	endtask
	task automatic t_mode();
		wr(ad(1, 5'h1F), 32'h1);
		wr(ad(0, 5'h13), 32'hFFFF);
		rd(ad(0, 5'h13), 32'hF81D, "mode_rb");
		chk("led_ext0", 4'hF, led_extended_mode[0]);
		chk("fast_pin", 1'b1, fast_link_fail_pin_en);
		chk("detect0", 2'b10, signal_detect[0]);
		chk("detect1", 2'b10, signal_detect[1]);
		for (int x = 0; x < 4; x++) begin
			wr(ad(0, 5'h13), 32'h0810 | (x << 2));
			chk("crossover", x[1:0], crossover_mode[0]);
		end
		wr(ad(1, 5'h13), 32'h0010);
		rd(ad(1, 5'h13), 32'h0, "mode_port1");
		chk("fast_pin_kept", 1'b1, fast_link_fail_pin_en);
		seen = 2'b00;
		@(posedge pclk);
		low_power_hold_pin <= 1'b0;
		repeat (6) begin
			@(posedge pclk);
			seen = seen | led_reset_blink;
		end
		chk("blink", 2'b10, seen);
		$display("test mode done");
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_pages();
		t_fiber();
		t_counter();
		t_mode();
		print_verdict();
	end
	// Run needs about 10.3k cycles; 30k leaves ample margin
	initial begin
		#300000;
		n_mismatch++;
		print_verdict();
	end
endmodule
`default_nettype wire
